// ---- rtl/sep_pkg.sv ----
// Constants shared by the serial EEPROM slave
package sep_pkg;
    localparam int unsigned SEP_CLK_PERIOD_NS = 8;
    localparam int unsigned SEP_WRITE_CYCLE_NS = 5000000;
    localparam int unsigned SEP_WRITE_CYCLES = SEP_WRITE_CYCLE_NS / SEP_CLK_PERIOD_NS;
    localparam int unsigned SEP_MEM_DEPTH = 128;
    localparam int unsigned SEP_ADDR_W = 7;
    localparam logic [6:0] SEP_DEV_ADDR = 7'h50;
    localparam logic [2:0] SEP_BIT_LAST = 3'h7;
    localparam logic [6:0] SEP_ADDR_RESET = 7'h00;
    localparam logic [7:0] SEP_BYTE_RESET = 8'h00;
    typedef enum logic [2:0] {
        SEP_IDLE, SEP_DEV, SEP_WADDR, SEP_WDATA, SEP_RDATA, SEP_RACK, SEP_IGNORE
    } sep_state_e;
endpackage

// ---- rtl/sep_line_if.sv ----
// Conditioned bus events passed from the line sampler to the core
`timescale 1ns/1ps
`default_nettype none
interface sep_line_if;
    logic scl_rise;
    logic scl_fall;
    logic sda_lvl;
    logic start;
    logic stop;
    modport src (output scl_rise, output scl_fall, output sda_lvl, output start, output stop);
    modport dst (input scl_rise, input scl_fall, input sda_lvl, input start, input stop);
endinterface
`default_nettype wire

// ---- rtl/sep_line_sync.sv ----
// Synchroniser and condition detector for the two bus lines
`timescale 1ns/1ps
`default_nettype none
module sep_line_sync (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic scl_i,
    input wire logic sda_i,
    sep_line_if.src ev
);
    logic [1:0] scl_sync_reg;
    logic [1:0] sda_sync_reg;
    logic scl_prev_reg;
    logic sda_prev_reg;

    // Two-flop synchronisers, then one more stage for edge history
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            scl_sync_reg <= 2'h3;
            sda_sync_reg <= 2'h3;
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end else begin
            scl_sync_reg <= {scl_sync_reg[0], scl_i};
            sda_sync_reg <= {sda_sync_reg[0], sda_i};
            scl_prev_reg <= scl_sync_reg[1];
            sda_prev_reg <= sda_sync_reg[1];
        end
    end

    // Edge and condition decode
    assign ev.scl_rise = scl_sync_reg[1] && !scl_prev_reg;
    assign ev.scl_fall = !scl_sync_reg[1] && scl_prev_reg;
    assign ev.sda_lvl = sda_sync_reg[1];
    assign ev.start = scl_sync_reg[1] && scl_prev_reg && sda_prev_reg && !sda_sync_reg[1];
    assign ev.stop = scl_sync_reg[1] && scl_prev_reg && !sda_prev_reg && sda_sync_reg[1];
endmodule // sep_line_sync
`default_nettype wire

// ---- rtl/sep_eeprom.sv ----
// Two-wire serial data EEPROM slave, 128 bytes
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - SDA rising while SCL high is STOP, ending the transaction.
// - STOP after a read returns to idle with data line released.
// - Transfers are 8-bit words; device pulls ACK low on ninth clock.
// - Device address after START is 1010 then 000.
// - Eighth address bit high means read, low means write.
// - Matching address is acknowledged; otherwise ignore until next START.
// - Byte write: word address then data, both acknowledged.
// - STOP after write starts timed write; bus ignored meanwhile.
// - No address ACK during write cycle; master may poll.
// - Current, random and sequential reads use read bit set.
// - Address counter holds last accessed address plus one.
// - Counter wraps from last byte to first on read.
// - Current read: ACK address, send byte at counter.
// - Random read: dummy write, repeated START, read address.
// - Master ACK makes device increment address and send next byte.
// - SDA falling while SCL high is START before every command.
// - Data changes only with SCL low; else START or STOP.
// - Sample on SCL rise, change output on SCL fall.
// - Array is 128 bytes; counter spans exactly that.
module sep_eeprom
    import sep_pkg::*;
#(
    parameter int unsigned WRITE_CYCLES = SEP_WRITE_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    output logic busy_o
);
    sep_line_if ev();
    sep_state_e state_reg;
    logic [7:0] mem [0:SEP_MEM_DEPTH-1];
    logic [2:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic ack_phase_reg;
    logic ninth_reg;
    logic give_ack_reg;
    logic [SEP_ADDR_W-1:0] addr_reg;
    logic [7:0] wdata_reg;
    logic wpend_reg;
    logic [31:0] wtimer_reg;
    logic busy_reg;
    logic oe_reg;
    logic [7:0] tx_reg;
    logic [7:0] rx_byte;
    logic byte_done;
    logic eighth_fall;
    logic ninth_fall;
    logic read_load;
    logic commit;
    logic [SEP_ADDR_W-1:0] addr_last;

    // Wrapping increment of the word address counter
    function automatic logic [SEP_ADDR_W-1:0] next_addr(input logic [SEP_ADDR_W-1:0] a);
        next_addr = a + 7'h01;
    endfunction

    // States in which bits of a byte are counted on the bus
    function automatic logic in_byte(input sep_state_e s);
        in_byte = (s == SEP_DEV) || (s == SEP_WADDR) || (s == SEP_WDATA) || (s == SEP_RDATA);
    endfunction

    sep_line_sync u_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .ev(ev)
    );

    // Byte and acknowledge slot events
    assign rx_byte = {shift_reg[6:0], ev.sda_lvl};
    assign byte_done = ev.scl_rise && !busy_reg && !ack_phase_reg && in_byte(state_reg)
                       && (bit_cnt_reg == SEP_BIT_LAST);
    assign eighth_fall = ev.scl_fall && ack_phase_reg && !ninth_reg;
    assign ninth_fall = ev.scl_fall && ack_phase_reg && ninth_reg;
    assign read_load = ninth_fall && (state_reg == SEP_RDATA);
    assign commit = ev.stop && wpend_reg && !busy_reg;
    assign addr_last = SEP_ADDR_W'(SEP_MEM_DEPTH - 1);

    // Open drain: the pin only ever pulls low, enable carries the level
    assign sda_o = 1'b0;
    assign sda_oe_o = oe_reg;
    assign busy_o = busy_reg;

    // ---------------------------------------------------------------
    // Protocol state machine and bit counting
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_reg <= SEP_IDLE;
            bit_cnt_reg <= 3'h0;
            shift_reg <= SEP_BYTE_RESET;
            ack_phase_reg <= 1'b0;
            ninth_reg <= 1'b0;
            give_ack_reg <= 1'b0;
            wdata_reg <= SEP_BYTE_RESET;
            wpend_reg <= 1'b0;
        end else if (busy_reg) begin
            // Bus is deaf while the array is being written
            state_reg <= SEP_IDLE;
            ack_phase_reg <= 1'b0;
            ninth_reg <= 1'b0;
            wpend_reg <= 1'b0;
        end else if (ev.start) begin
            // Any START, even mid-byte, resynchronises and drops a pending write
            state_reg <= SEP_DEV;
            bit_cnt_reg <= 3'h0;
            ack_phase_reg <= 1'b0;
            ninth_reg <= 1'b0;
            give_ack_reg <= 1'b0;
            wpend_reg <= 1'b0;
        end else if (ev.stop) begin
            state_reg <= SEP_IDLE;
            bit_cnt_reg <= 3'h0;
            ack_phase_reg <= 1'b0;
            ninth_reg <= 1'b0;
            give_ack_reg <= 1'b0;
            wpend_reg <= 1'b0;
        end else if (ev.scl_rise) begin
            if (ack_phase_reg) begin
                // Ninth bit of a byte sent by the device: master ACK keeps reading
                if (ninth_reg && state_reg == SEP_RACK) begin
                    state_reg <= ev.sda_lvl ? SEP_IGNORE : SEP_RDATA;
                end
            end else if (in_byte(state_reg)) begin
                shift_reg <= rx_byte;
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
            end
            if (byte_done) begin
                ack_phase_reg <= 1'b1;
                case (state_reg)
                    SEP_DEV: begin
                        if (rx_byte[7:1] == SEP_DEV_ADDR) begin
                            give_ack_reg <= 1'b1;
                            state_reg <= rx_byte[0] ? SEP_RDATA : SEP_WADDR;
                        end else begin
                            give_ack_reg <= 1'b0;
                            state_reg <= SEP_IGNORE;
                        end
                    end
                    SEP_WADDR: begin
                        give_ack_reg <= 1'b1;
                        state_reg <= SEP_WDATA;
                    end
                    SEP_WDATA: begin
                        give_ack_reg <= 1'b1;
                        wdata_reg <= rx_byte;
                        state_reg <= SEP_IGNORE;
                    end
                    SEP_RDATA: begin
                        give_ack_reg <= 1'b0; // Master owns the ninth bit
                        state_reg <= SEP_RACK;
                    end
                    default: begin
                        give_ack_reg <= 1'b0;
                        state_reg <= SEP_IGNORE;
                    end
                endcase
            end
        end else if (ev.scl_fall && ack_phase_reg) begin
            if (!ninth_reg) begin
                ninth_reg <= 1'b1;
            end else begin
                ack_phase_reg <= 1'b0;
                ninth_reg <= 1'b0;
                // Data byte fully acknowledged: arm the write for the next STOP
                if (state_reg == SEP_IGNORE && give_ack_reg) begin
                    wpend_reg <= 1'b1;
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // Word address counter, read shifter and data line drive
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            addr_reg <= SEP_ADDR_RESET;
            tx_reg <= SEP_BYTE_RESET;
            oe_reg <= 1'b0;
        end else if (busy_reg) begin
            oe_reg <= 1'b0;
        end else if (ev.start) begin
            oe_reg <= 1'b0;
        end else if (ev.stop) begin
            oe_reg <= 1'b0;
            if (wpend_reg) begin
                addr_reg <= next_addr(addr_reg);
            end
        end else if (byte_done && state_reg == SEP_WADDR) begin
            addr_reg <= rx_byte[SEP_ADDR_W-1:0];
        end else if (eighth_fall) begin
            oe_reg <= give_ack_reg;
        end else if (read_load) begin
            tx_reg <= mem[addr_reg];
            oe_reg <= !mem[addr_reg][7];
            addr_reg <= next_addr(addr_reg);
        end else if (ninth_fall) begin
            oe_reg <= 1'b0;
        end else if (ev.scl_fall && state_reg == SEP_RDATA && !ack_phase_reg) begin
            tx_reg <= {tx_reg[6:0], 1'b1};
            oe_reg <= !tx_reg[6];
        end
    end

    // ---------------------------------------------------------------
    // Internally timed write cycle
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            busy_reg <= 1'b0;
            wtimer_reg <= 32'h0;
        end else if (busy_reg) begin
            if (wtimer_reg == 32'(WRITE_CYCLES - 1)) begin
                busy_reg <= 1'b0;
            end
            wtimer_reg <= wtimer_reg + 32'h1;
        end else if (commit) begin
            busy_reg <= 1'b1;
            wtimer_reg <= 32'h0;
        end
    end

    // Array store on the STOP that closes a complete byte write
    always_ff @(posedge clk_i) begin
        if (rst_n_i && commit) begin
            mem[addr_reg] <= wdata_reg;
        end
    end

    // ---------------------------------------------------------------
    // Protocol assertions
    // ---------------------------------------------------------------
    default clocking cb_core @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    // STOP after a fully acknowledged data byte
    sequence s_commit;
        ev.stop && wpend_reg && !busy_reg;
    endsequence
    // Last bit of a device address that does not match
    sequence s_bad_dev;
        byte_done && (state_reg == SEP_DEV) && (rx_byte[7:1] != SEP_DEV_ADDR);
    endsequence
    // Last byte of the array handed to the read shifter
    sequence s_last_read;
        read_load && (addr_reg == addr_last);
    endsequence

    property p_write_begin;
        s_commit |=> busy_reg;
    endproperty
    a_write_begin: assert property (p_write_begin)
        else $error("write cycle not started after stop");

    property p_busy_quiet;
        busy_reg |-> !oe_reg;
    endproperty
    a_busy_quiet: assert property (p_busy_quiet)
        else $error("data line driven during write cycle");

    property p_busy_end;
        busy_reg && (wtimer_reg == 32'(WRITE_CYCLES - 1)) |=> !busy_reg;
    endproperty
    a_busy_end: assert property (p_busy_end)
        else $error("write cycle did not end on time");

    property p_stop_idle;
        ev.stop |=> (state_reg == SEP_IDLE) && !oe_reg;
    endproperty
    a_stop_idle: assert property (p_stop_idle)
        else $error("stop did not return to standby");

    property p_start_dev;
        ev.start && !busy_reg |=> state_reg == SEP_DEV;
    endproperty
    a_start_dev: assert property (p_start_dev)
        else $error("start did not open an address byte");

    property p_bad_dev;
        s_bad_dev |=> (state_reg == SEP_IGNORE) && !give_ack_reg;
    endproperty
    a_bad_dev: assert property (p_bad_dev)
        else $error("foreign address not ignored");

    property p_ack_drive;
        eighth_fall && give_ack_reg && !busy_reg |=> oe_reg;
    endproperty
    a_ack_drive: assert property (p_ack_drive)
        else $error("acknowledge not driven in ninth slot");

    property p_wrap;
        s_last_read |=> addr_reg == SEP_ADDR_RESET;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("address counter did not wrap");
endmodule // sep_eeprom
`default_nettype wire

// ---- verification/sep_master.sv ----
// Behavioural two-wire bus master with a pull-up on the data line
`timescale 1ns/1ps
`default_nettype none
module sep_master #(
    parameter int HALF_NS = 200
) (
    input wire logic dev_oe_i,
    output logic scl_o,
    output logic sda_o
);
    logic pull_low;
    // Pull-up wins unless one of the parties pulls low
    assign sda_o = ~pull_low & ~dev_oe_i;
    initial begin
        scl_o = 1'b1;
        pull_low = 1'b0;
    end
    // One clock pulse: data set while low, line read at the end of high
    task automatic bit_cyc(input logic b, output logic r);
        pull_low = ~b;
        #(HALF_NS);
        scl_o = 1'b1;
        #(HALF_NS);
        r = sda_o;
        scl_o = 1'b0;
        #(HALF_NS / 4);
    endtask
    // Data falls while the clock is high
    task automatic start_cond();
        pull_low = 1'b0;
        #(HALF_NS);
        scl_o = 1'b1;
        #(HALF_NS);
        pull_low = 1'b1;
        #(HALF_NS);
        scl_o = 1'b0;
        #(HALF_NS / 4);
    endtask
    // Data rises while the clock is high; clock then stays high
    task automatic stop_cond();
        pull_low = 1'b1;
        #(HALF_NS);
        scl_o = 1'b1;
        #(HALF_NS);
        pull_low = 1'b0;
        #(HALF_NS);
    endtask
    // Sends a byte MSB first and reads the ninth bit
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_cyc(d[i], r);
        end
        bit_cyc(1'b1, r);
        ack = ~r;
    endtask
    // Reads a byte MSB first, then acknowledges or declines
    task automatic get_byte(input logic ack_it, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_cyc(1'b1, r);
            d[i] = r;
        end
        bit_cyc(~ack_it, r);
    endtask
endmodule // sep_master
`default_nettype wire

// ---- verification/sep_eeprom_tb.sv ----
// Self-checking bench for the serial EEPROM slave
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin bad_count++; \
    $display("BAD %0t got %0h expected %0h", $time, got, exp); end end
module sep_eeprom_tb;
    import sep_pkg::*;
    localparam int unsigned WC = 500;
    localparam int LIMIT = 80000;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic dev_sda;
    logic sda_oe;
    logic busy;
    wire scl_w;
    wire sda_w;
    int bad_count = 0;
    int checked = 0;
    int cycles = 0;
    logic ack;
    logic [7:0] d;
    always #(SEP_CLK_PERIOD_NS / 2) clk_i = ~clk_i;
    sep_eeprom #(.WRITE_CYCLES(WC)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl_w),
        .sda_i(sda_w), .sda_o(dev_sda), .sda_oe_o(sda_oe), .busy_o(busy));
    // Bus clock period of 72 ns
    sep_master #(.HALF_NS(32)) mst (.dev_oe_i(sda_oe), .scl_o(scl_w), .sda_o(sda_w));
    task automatic final_report();
        $display("bad_count=%0d checked=%0d", bad_count, checked);
        if (bad_count == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Write device address and word address, both acknowledged
    task automatic addr_phase(input logic [7:0] waddr);
        mst.start_cond();
        mst.send_byte({SEP_DEV_ADDR, 1'b0}, ack);
        `CHK(ack, 1'b1)
        mst.send_byte(waddr, ack);
        `CHK(ack, 1'b1)
    endtask
    // Byte write, then polling through the write cycle
    task automatic t_write(input logic [7:0] waddr, input logic [7:0] data);
        int n;
        addr_phase(waddr);
        mst.send_byte(data, ack);
        `CHK(ack, 1'b1)
        mst.stop_cond();
        `CHK(busy, 1'b1)
        mst.start_cond();
        mst.send_byte({SEP_DEV_ADDR, 1'b0}, ack);
        `CHK(ack, 1'b0)
        for (n = 0; n < 20 && !ack; n++) begin
            mst.stop_cond();
            mst.start_cond();
            mst.send_byte({SEP_DEV_ADDR, 1'b0}, ack);
        end
        `CHK(ack, 1'b1)
        mst.stop_cond();
    endtask
    // Dummy write, repeated start, read address
    task automatic read_setup(input logic [7:0] waddr);
        addr_phase(waddr);
        mst.start_cond();
        mst.send_byte({SEP_DEV_ADDR, 1'b1}, ack);
        `CHK(ack, 1'b1)
    endtask
    task automatic t_rand_read(input logic [7:0] waddr, input logic [7:0] exp);
        read_setup(waddr);
        mst.get_byte(1'b0, d);
        `CHK(d, exp)
        mst.stop_cond();
    endtask
    task automatic t_cur_read(input logic [7:0] exp);
        mst.start_cond();
        mst.send_byte({SEP_DEV_ADDR, 1'b1}, ack);
        `CHK(ack, 1'b1)
        mst.get_byte(1'b0, d);
        `CHK(d, exp)
        mst.stop_cond();
        `CHK(sda_oe, 1'b0)
        `CHK(dev_sda, 1'b0)
    endtask
    task automatic t_seq_read();
        read_setup(8'h7F);
        mst.get_byte(1'b1, d);
        `CHK(d, 8'h3C)
        mst.get_byte(1'b0, d);
        `CHK(d, 8'h5A)
        mst.stop_cond();
    endtask
    // Addresses with wrong fixed bits are ignored
    task automatic t_bad_addr();
        logic [7:0] bad [2] = '{8'hA2, 8'hB0};
        foreach (bad[i]) begin
            mst.start_cond();
            mst.send_byte(bad[i], ack);
            `CHK(ack, 1'b0)
            mst.stop_cond();
        end
    endtask
    // Stop after half a data byte must not write
    task automatic t_abort();
        addr_phase(8'h00);
        repeat (4) mst.bit_cyc(1'b0, ack);
        mst.stop_cond();
        `CHK(busy, 1'b0)
        t_rand_read(8'h00, 8'h5A);
    endtask
    // Cuts a hang short
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            bad_count++;
            final_report();
        end
    end
    initial begin
        repeat (2) @(posedge clk_i);
        #1 rst_n_i = 1'b1;
        repeat (4) @(posedge clk_i);
        #1;
        t_write(8'hFF, 8'h3C);
        t_write(8'h00, 8'h5A);
        t_bad_addr();
        t_rand_read(8'h7F, 8'h3C);
        t_cur_read(8'h5A);
        t_seq_read();
        t_abort();
        final_report();
    end
endmodule // sep_eeprom_tb
`default_nettype wire
